// [debug_port_ctrl.sv]
// Enable, pin sharing, breakpoints and link of the two-wire debug port.
`timescale 1ns/1ps
`default_nettype none
`include "debug_port_defs.svh"
module debug_port_ctrl
  import debug_port_pkg::*;
#(
  parameter int AW  = 16,
  parameter int NBP = 4
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Register bus
  input  wire logic [4:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [15:0]   reg_rdata,
  // Fuses and boot state
  input  wire logic          fuse_debug_n,
  input  wire logic          lock_bit_set,
  input  wire logic          boot_jump_bit,
  input  wire logic          hw_boot_entry,
  input  wire logic          por_active,
  // Shared pins
  input  wire logic          rst_pin,
  input  wire logic          pin43_in,
  output logic               pin43_out,
  output logic               pin43_oe,
  // Port 4 bit 3 general-purpose side
  input  wire logic          gpio43_out,
  input  wire logic          gpio43_oe,
  output logic               gpio43_in,
  // Reset and programming control
  output logic               ext_reset,
  output logic               isp_entry_ok,
  output logic               reset_out_ok,
  output logic               target_reset,
  // CPU side
  input  wire logic [AW-1:0] cpu_pc,
  input  wire logic [AW-1:0] cpu_daddr,
  input  wire logic          cpu_dvalid,
  input  wire logic          cpu_break_insn,
  input  wire logic          cpu_insn_done,
  input  wire logic          stack_fault,
  input  wire logic          wdt_overflow,
  input  wire logic          cpu_reset_evt,
  input  wire logic          flow_change,
  output logic               cpu_halt,
  output logic               handler_entry,
  output logic               break_nop,
  output logic      [AW-1:0] resume_pc,
  // Memory and register access for the link
  output logic      [AW-1:0] mem_addr,
  output logic      [7:0]    mem_wdata,
  output logic               mem_we,
  output logic               mem_re,
  input  wire logic [7:0]    mem_rdata,
  // Status
  output logic               debug_active,
  output logic               irq
);
  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  logic dcl_s1_q, dcl_s2_q, dcl_s3_q, dda_s1_q, dda_s2_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dcl_s1_q <= 1'b0;
      dcl_s2_q <= 1'b0;
      dcl_s3_q <= 1'b0;
      dda_s1_q <= 1'b0;
      dda_s2_q <= 1'b0;
    end else begin
      dcl_s1_q <= rst_pin;
      dcl_s2_q <= dcl_s1_q;
      dcl_s3_q <= dcl_s2_q;
      dda_s1_q <= pin43_in;
      dda_s2_q <= dda_s1_q;
    end
  end
  logic dcl_rise, dcl_fall;
  assign dcl_rise = dcl_s2_q & ~dcl_s3_q;
  assign dcl_fall = ~dcl_s2_q & dcl_s3_q;
  // ***************************************************
  // Enable and pin takeover
  // ***************************************************
  logic en_d, dbg_q;
  // Cleared fuse, no lock bit, no bootloader.
  assign en_d = ~fuse_debug_n & ~lock_bit_set
              & boot_jump_bit & ~hw_boot_entry;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dbg_q        <= 1'b0;
      ext_reset    <= 1'b0;
      isp_entry_ok <= 1'b0;
      reset_out_ok <= 1'b0;
      gpio43_in    <= 1'b0;
    end else begin
      dbg_q        <= en_d;
      ext_reset    <= ~en_d & dcl_s2_q;
      isp_entry_ok <= ~en_d | por_active & dcl_s2_q;
      reset_out_ok <= ~en_d | por_active;
      gpio43_in    <= ~en_d & dda_s2_q;
    end
  end
  assign debug_active = dbg_q;
  // ***************************************************
  // Registers
  // ***************************************************
  logic [`EV_W-1:0] status_q, mask_q, ev;
  logic [15:0]      bpcfg_q;
  logic [3:0]       hsrc_q;
  logic [AW-1:0]    bp_q [2*NBP];
  logic             rd_status;
  assign rd_status = reg_rd & (reg_addr == `A_STATUS);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_q  <= '0;
      bpcfg_q <= 16'h0000;
      hsrc_q  <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == `A_MASK) mask_q <= reg_wdata[`EV_W-1:0];
      if (reg_addr == `A_BPCFG) bpcfg_q <= reg_wdata;
      if (reg_addr == `A_HALTSRC) hsrc_q <= reg_wdata[3:0];
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 2*NBP; gi++) begin : g_bpreg
      always_ff @(posedge clk) begin
        if (!rstn) begin
          bp_q[gi] <= '0;
        end else if (reg_wr &&
                     reg_addr == `A_BPBASE + 5'(gi)) begin
          bp_q[gi] <= reg_wdata[AW-1:0];
        end
      end
    end
  endgenerate
  // Setting wins over the clear done by a status read.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_q <= '0;
      irq      <= 1'b0;
    end else begin
      status_q <= (rd_status ? '0 : status_q) | ev;
      irq      <= |(((rd_status ? '0 : status_q) | ev) & mask_q);
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr >= `A_BPBASE &&
                 reg_addr < `A_BPBASE + 5'(2*NBP)) begin
      reg_rdata <= 16'(bp_q[3'(reg_addr - `A_BPBASE)]);
    end else begin
      unique case (reg_addr)
        `A_STATUS:  reg_rdata <= 16'(status_q);
        `A_MASK:    reg_rdata <= 16'(mask_q);
        `A_BPCFG:   reg_rdata <= bpcfg_q;
        `A_HALTSRC: reg_rdata <= 16'(hsrc_q);
        `A_STATE:   reg_rdata <= {12'h000, lock_bit_set,
                                  ~boot_jump_bit | hw_boot_entry,
                                  cpu_halt, dbg_q};
        default:    reg_rdata <= 16'h0000;
      endcase
    end
  end
  // ***************************************************
  // Breakpoints
  // ***************************************************
  function automatic logic addr_hit(input logic [AW-1:0] a,
                                    input logic [AW-1:0] r,
                                    input logic [AW-1:0] m);
    addr_hit = ((a ^ r) & ~m) == '0;
  endfunction : addr_hit
  logic [NBP-1:0] pc_hit, pd_hit;
  generate
    for (gi = 0; gi < NBP; gi++) begin : g_pcbp
      assign pc_hit[gi] = bpcfg_q[gi]
                        & addr_hit(cpu_pc, bp_q[gi], '0);
    end
    for (gi = 0; gi < NBP; gi++) begin : g_pdbp
      logic          dsel, pmask;
      logic [AW-1:0] msk, a;
      assign dsel  = bpcfg_q[`CFG_TYPE + gi];
      assign pmask = bpcfg_q[`CFG_PMASK + gi/2];
      assign a     = dsel ? cpu_daddr : cpu_pc;
      // In masked mode the odd member is the mask of the even one.
      assign msk   = (pmask && gi % 2 == 0) ? bp_q[NBP + (gi | 1)] : '0;
      assign pd_hit[gi] = bpcfg_q[NBP + gi]
                        & (~dsel | cpu_dvalid)
                        & ~(pmask && gi % 2 == 1)
                        & addr_hit(a, bp_q[NBP+gi], msk);
    end
  endgenerate
  logic bp_any, cond_any, brk_dbg;
  assign bp_any   = |pc_hit | |pd_hit;
  assign cond_any = hsrc_q[`HS_STACK] & stack_fault
                  | hsrc_q[`HS_WDT] & wdt_overflow
                  | hsrc_q[`HS_RST] & cpu_reset_evt
                  | hsrc_q[`HS_FLOW] & flow_change;
  assign brk_dbg = dbg_q & cpu_break_insn & ~cpu_halt;
  assign ev[`EV_BP]   = dbg_q & ~cpu_halt & bp_any;
  assign ev[`EV_BRK]  = brk_dbg;
  assign ev[`EV_COND] = dbg_q & ~cpu_halt & cond_any;
  assign ev[`EV_LRST] = target_reset;
  // ***************************************************
  // Halt instruction and flow control
  // ***************************************************
  logic     step_q, op_run, op_halt, op_step, nop_cnt_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cpu_halt      <= 1'b0;
      step_q        <= 1'b0;
      handler_entry <= 1'b0;
      resume_pc     <= '0;
    end else begin
      handler_entry <= brk_dbg;
      if (brk_dbg) resume_pc <= cpu_pc + AW'(`HALT_INSN_BYTES);
      if (!dbg_q) begin
        cpu_halt <= 1'b0;
        step_q   <= 1'b0;
      end else if (op_run || op_step) begin
        cpu_halt <= 1'b0;
        step_q   <= op_step;
      end else if (op_halt || ev[`EV_BP] || ev[`EV_BRK] ||
                   ev[`EV_COND] || (step_q && cpu_insn_done)) begin
        cpu_halt <= 1'b1;
        step_q   <= 1'b0;
      end
    end
  end
  // A disabled halt instruction stalls nothing and lasts two cycles.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      break_nop <= 1'b0;
      nop_cnt_q <= 1'b0;
    end else begin
      nop_cnt_q <= !dbg_q && cpu_break_insn && !break_nop;
      break_nop <= (!dbg_q && cpu_break_insn && !break_nop) | nop_cnt_q;
    end
  end
  // ***************************************************
  // Serial link
  // ***************************************************
  link_state_t           lst_q;
  logic [`FRAME_BITS-1:0] sh_q;
  logic [4:0]             cnt_q;
  logic [`REPLY_BITS-1:0] rep_q;
  link_op_t               op;
  assign op      = link_op_t'(sh_q[`OP_MSB -: 3]);
  assign op_run  = lst_q == L_EXEC && op == OP_RUN;
  assign op_halt = lst_q == L_EXEC && op == OP_HALT;
  assign op_step = lst_q == L_EXEC && op == OP_STEP;
  always_ff @(posedge clk) begin
    if (!rstn || !dbg_q) begin
      lst_q        <= L_RX;
      sh_q         <= '0;
      cnt_q        <= 5'h00;
      rep_q        <= '0;
      mem_we       <= 1'b0;
      mem_re       <= 1'b0;
      mem_addr     <= '0;
      mem_wdata    <= 8'h00;
      target_reset <= 1'b0;
    end else begin
      mem_we       <= 1'b0;
      mem_re       <= 1'b0;
      target_reset <= 1'b0;
      unique case (lst_q)
        L_RX: if (dcl_rise) begin
          sh_q  <= {sh_q[`FRAME_BITS-2:0], dda_s2_q};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'(`FRAME_BITS - 1)) lst_q <= L_EXEC;
        end
        L_EXEC: begin
          mem_addr  <= sh_q[`ADDR_MSB -: AW];
          mem_wdata <= sh_q[7:0];
          mem_re    <= op == OP_READ;
          mem_we    <= op == OP_WRITE;
          target_reset <= op == OP_RESET;
          lst_q <= op == OP_READ ? L_WAIT : L_RX;
        end
        L_WAIT: begin
          rep_q <= mem_rdata;
          cnt_q <= 5'h00;
          lst_q <= L_REPLY;
        end
        L_REPLY: if (dcl_fall) begin
          rep_q <= {rep_q[`REPLY_BITS-2:0], 1'b0};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'(`REPLY_BITS - 1)) begin
            cnt_q <= 5'h00;
            lst_q <= L_RX;
          end
        end
      endcase
    end
  end
  // The data pin is owned by the link whenever debug is enabled.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin43_out <= 1'b0;
      pin43_oe  <= 1'b0;
    end else if (en_d) begin
      pin43_out <= rep_q[`REPLY_BITS-1];
      pin43_oe  <= dbg_q && lst_q == L_REPLY &&
                   !(dcl_fall && cnt_q == 5'(`REPLY_BITS - 1));
    end else begin
      pin43_out <= gpio43_out;
      pin43_oe  <= gpio43_oe;
    end
  end
  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_nop_start;
    !dbg_q && cpu_break_insn && !break_nop;
  endsequence
  sequence s_two_nop;
    break_nop [*2] ##1 !break_nop;
  endsequence
  property p_en;
    ##1 1'b1 |-> dbg_q == $past(en_d);
  endproperty
  a_en: assert property (p_en) else $error("enable mismatch");
  property p_lock;
    lock_bit_set |=> !dbg_q;
  endproperty
  a_lock: assert property (p_lock) else $error("lock ignored");
  property p_boot;
    (!boot_jump_bit || hw_boot_entry) |=> !dbg_q;
  endproperty
  a_boot: assert property (p_boot) else $error("boot ignored");
  property p_rstin;
    en_d |=> !ext_reset && !gpio43_in;
  endproperty
  a_rstin: assert property (p_rstin) else $error("pin leak");
  property p_rstout;
    (en_d && !por_active) |=> !reset_out_ok;
  endproperty
  a_rstout: assert property (p_rstout) else $error("rst out");
  property p_nop;
    s_nop_start |=> s_two_nop;
  endproperty
  a_nop: assert property (p_nop) else $error("nop length");
  property p_brk;
    brk_dbg |=> handler_entry && cpu_halt &&
      resume_pc == $past(cpu_pc) + AW'(`HALT_INSN_BYTES);
  endproperty
  a_brk: assert property (p_brk) else $error("break entry");
  property p_cond;
    (dbg_q && !cpu_halt && cond_any && !op_run && !op_step)
      |=> cpu_halt;
  endproperty
  a_cond: assert property (p_cond) else $error("no halt");
  property p_rd;
    (lst_q == L_EXEC && op == OP_READ) |=> mem_re ##2 lst_q == L_REPLY;
  endproperty
  a_rd: assert property (p_rd) else $error("read path");
endmodule : debug_port_ctrl
`default_nettype wire

// [debug_port_defs.svh]
// Offsets, fields and counts of the two-wire debug port controller.
// Function
// - Debug port is active only while its enable fuse reads cleared.
// - With debug enabled, reset pin becomes the input for the debug clock.
// - With debug enabled, port 4 bit 3 becomes the two-way debug data line.
// - Enabling debug disables external reset input and serial programming entry.
// - With debug enabled, programming entry only by reset held at power-up.
// - Active bootloader, by boot jump bit low or hardware entry, blocks debug.
// - With debug disabled, the halt instruction is a two-cycle no-operation.
// - With debug enabled, target reset comes only from the debug link.
// - With debug enabled, reset output is suppressed except during power-on reset.
// - In debug mode the data pin loses its general-purpose function entirely.
// - Any programmed hardware lock bit forces debug into the disabled state.
// - Four hardware breakpoints compare against the program address.
// - Four more program/data breakpoints in two pairs, one member masking other.
// - Halt on stack fault, watchdog overflow, reset and program flow change.
// - Link gives separate read and write access to registers and memory, plus flow control.
// - Enabled halt instruction enters handler, next-instruction pc, flags untouched.
`ifndef DEBUG_PORT_DEFS_SVH
`define DEBUG_PORT_DEFS_SVH
// ***************************************************
// Register offsets
// ***************************************************
`define A_STATUS   5'h00
`define A_MASK     5'h01
`define A_BPCFG    5'h02
`define A_HALTSRC  5'h03
`define A_STATE    5'h04
`define A_BPBASE   5'h08
// ***************************************************
// Fields
// ***************************************************
`define EV_BP      0
`define EV_BRK     1
`define EV_COND    2
`define EV_LRST    3
`define EV_W       4
`define CFG_PMASK  8
`define CFG_TYPE   10
`define HS_STACK   0
`define HS_WDT     1
`define HS_RST     2
`define HS_FLOW    3
`define HALT_INSN_BYTES 16'h0002
// ***************************************************
// Link framing
// ***************************************************
`define FRAME_BITS 32
`define REPLY_BITS 8
`define OP_MSB     31
`define ADDR_MSB   23
`endif

// [debug_port_pkg.sv]
// Types shared by the debug port controller.
`default_nettype none
package debug_port_pkg;
  typedef enum logic [1:0] {
    L_RX    = 2'b00,
    L_EXEC  = 2'b01,
    L_WAIT  = 2'b11,
    L_REPLY = 2'b10
  } link_state_t;
  typedef enum logic [2:0] {
    OP_NOP   = 3'h0,
    OP_READ  = 3'h1,
    OP_WRITE = 3'h2,
    OP_RUN   = 3'h4,
    OP_HALT  = 3'h5,
    OP_STEP  = 3'h6,
    OP_RESET = 3'h7
  } link_op_t;
endpackage : debug_port_pkg
`default_nettype wire

// [debug_emulator_model.sv]
// Emulator model that drives the debug clock and the shared data line.
`timescale 1ns/1ps
`default_nettype none
module debug_emulator_model (
  // System clock, used only for the idle pattern
  input  wire logic clk,
  // Shared pins
  output logic      debug_clock_pin,
  output logic      dq_out,
  output logic      dq_oe,
  input  wire logic dq_in
);
  logic bit_q = 1'b0;
  logic pat   = 1'b0;
  // A released line shows a changing level, never the last bit driven.
  assign dq_out = dq_oe ? bit_q : pat;
  always @(posedge clk) begin
    pat <= ~pat;
  end
  initial begin
    debug_clock_pin = 1'b0;
    dq_oe = 1'b0;
  end
  // Reset pin level while the pin still serves as a reset input.
  task automatic set_pin(input logic v);
    debug_clock_pin = v;
  endtask : set_pin
  task automatic hold(input logic v);
    dq_oe = 1'b1;
    bit_q = v;
  endtask : hold
  // Shifts one frame, MSB first; the clock is left high after bit 0.
  task automatic send(input logic [31:0] f);
    for (int i = 31; i >= 0; i--) begin
      debug_clock_pin = 1'b0;
      dq_oe = 1'b1;
      bit_q = f[i];
      #200;
      debug_clock_pin = 1'b1;
      #200;
    end
  endtask : send
  // The clock idles low between frames.
  task automatic finish_frame();
    debug_clock_pin = 1'b0;
    dq_oe = 1'b0;
    #400;
  endtask : finish_frame
  // Reads the reply, sampling bit 7 before the first falling edge and each later bit just before a rising edge.
  task automatic get_reply(output logic [7:0] r);
    dq_oe = 1'b0;
    #400;
    r[7] = dq_in;
    for (int i = 6; i >= 0; i--) begin
      debug_clock_pin = 1'b0;
      #200;
      r[i] = dq_in;
      debug_clock_pin = 1'b1;
      #200;
    end
    debug_clock_pin = 1'b0;
    #400;
  endtask : get_reply
endmodule : debug_emulator_model
`default_nettype wire

// [two_wire_debug_port_control_bench.sv]
// Self-checking bench for the two-wire debug port controller.
`timescale 1ns/1ps
`default_nettype none
`include "debug_port_defs.svh"
module two_wire_debug_port_control_bench;
  import debug_port_pkg::*;
  logic clk, rstn, reg_wr, reg_rd, fuse_debug_n, lock_bit_set, dq_oe;
  logic boot_jump_bit, hw_boot_entry, por_active, debug_clock_pin, dq_out, pin43_wire;
  logic pin43_out, pin43_oe, gpio43_out, gpio43_oe, gpio43_in, ext_reset;
  logic isp_entry_ok, reset_out_ok, target_reset, cpu_dvalid, irq;
  logic cpu_break_insn, cpu_insn_done, cpu_halt, handler_entry, break_nop;
  logic mem_we, mem_re, debug_active;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cpu_pc, cpu_daddr, resume_pc, mem_addr;
  logic [15:0] we_a;
  logic [7:0] mem_wdata, mem_rdata, we_d, rep;
  logic [3:0] ev;
  int miscompares = 0;
  int tests_run = 0;
  int he_n = 0, tr_n = 0, bn_n = 0, we_n = 0, re_n = 0, n0;
  assign pin43_wire = (pin43_oe === 1'b1) ? pin43_out : dq_out;
  debug_port_ctrl debug_port_ctrl_inst (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fuse_debug_n(fuse_debug_n), .lock_bit_set(lock_bit_set),
    .boot_jump_bit(boot_jump_bit), .hw_boot_entry(hw_boot_entry),
    .por_active(por_active), .rst_pin(debug_clock_pin), .pin43_in(pin43_wire),
    .pin43_out(pin43_out), .pin43_oe(pin43_oe), .gpio43_out(gpio43_out),
    .gpio43_oe(gpio43_oe), .gpio43_in(gpio43_in), .ext_reset(ext_reset),
    .isp_entry_ok(isp_entry_ok), .reset_out_ok(reset_out_ok),
    .target_reset(target_reset), .cpu_pc(cpu_pc), .cpu_daddr(cpu_daddr),
    .cpu_dvalid(cpu_dvalid), .cpu_break_insn(cpu_break_insn),
    .cpu_insn_done(cpu_insn_done), .stack_fault(ev[0]),
    .wdt_overflow(ev[1]), .cpu_reset_evt(ev[2]), .flow_change(ev[3]),
    .cpu_halt(cpu_halt), .handler_entry(handler_entry),
    .break_nop(break_nop), .resume_pc(resume_pc), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_rdata(mem_rdata), .debug_active(debug_active), .irq(irq));
  debug_emulator_model debug_emulator_model_inst (
    .clk(clk), .debug_clock_pin(debug_clock_pin), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(pin43_wire));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Counts the cycles in which each pulse is high (two per break_nop) so that tests can check how many occurred.
  always @(posedge clk) begin
    if (handler_entry === 1'b1) he_n <= he_n + 1;
    if (target_reset === 1'b1) tr_n <= tr_n + 1;
    if (break_nop === 1'b1) bn_n <= bn_n + 1;
    if (mem_re === 1'b1) re_n <= re_n + 1;
    if (mem_we === 1'b1) begin
      we_n <= we_n + 1;
      we_a <= mem_addr;
      we_d <= mem_wdata;
    end
  end
  task automatic check_bit(input string n, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask : check_bit
  task automatic check_word(input string n, input logic [15:0] e,
                            input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check_word
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e,
                    input string n);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check_word(n, e, reg_rdata);
  endtask : rd
  task automatic frame(input link_op_t op, input logic [15:0] a,
                       input logic [7:0] d);
    debug_emulator_model_inst.send({op, 5'h00, a, d});
    debug_emulator_model_inst.finish_frame();
  endtask : frame
  // Checks a halt, reads and clears its status, then resumes the CPU.
  task automatic hit(input logic [15:0] st);
    #1 check_bit("cpu_halt", 1'b1, cpu_halt);
    rd(`A_STATUS, st, "status");
    rd(`A_STATUS, 16'h0000, "status cleared");
    frame(OP_RUN, 16'h0000, 8'h00);
    tick(2);
    #1 check_bit("cpu_halt run", 1'b0, cpu_halt);
  endtask : hit
  initial begin
    #4000000;
    miscompares++;
    print_verdict();
  end
  initial begin
    {rstn, reg_wr, reg_rd, lock_bit_set, hw_boot_entry, por_active} = 6'h00;
    {cpu_dvalid, cpu_break_insn, cpu_insn_done, gpio43_out} = 4'h0;
    fuse_debug_n = 1'b1;
    boot_jump_bit = 1'b1;
    gpio43_oe = 1'b1;
    {reg_addr, reg_wdata, cpu_daddr, ev} = '0;
    cpu_pc = 16'hFFF0;
    mem_rdata = 8'hC3;
    tick(16);
    rstn <= 1'b1;
    gpio43_out <= 1'b1;
    tick(4);
    #1 check_bit("debug_active off", 1'b0, debug_active);
    check_bit("pin oe", 1'b1, pin43_oe);
    check_bit("pin out", 1'b1, pin43_out);
    tick(1);
    gpio43_oe <= 1'b0;
    for (int v = 0; v < 2; v++) begin
      debug_emulator_model_inst.hold(v[0]);
      tick(5);
      #1 check_bit("gpio in", v[0], gpio43_in);
    end
    debug_emulator_model_inst.set_pin(1'b1);
    tick(5);
    #1 check_bit("ext_reset", 1'b1, ext_reset);
    debug_emulator_model_inst.set_pin(1'b0);
    n0 = he_n;
    tick(1);
    cpu_break_insn <= 1'b1;
    tick(1);
    cpu_break_insn <= 1'b0;
    gpio43_oe <= 1'b1;
    fuse_debug_n <= 1'b0;
    tick(6);
    #1 check_word("nop cycles", 16'h0002, 16'(bn_n));
    check_word("no handler", 16'(n0), 16'(he_n));
    check_bit("debug_active", 1'b1, debug_active);
    check_bit("gpio in dbg", 1'b0, gpio43_in);
    check_bit("pin oe dbg", 1'b0, pin43_oe);
    debug_emulator_model_inst.set_pin(1'b1);
    tick(5);
    #1 check_bit("ext_reset dbg", 1'b0, ext_reset);
    check_bit("isp entry", 1'b0, isp_entry_ok);
    check_bit("reset out", 1'b0, reset_out_ok);
    tick(1);
    por_active <= 1'b1;
    tick(3);
    #1 check_bit("isp entry por", 1'b1, isp_entry_ok);
    check_bit("reset out por", 1'b1, reset_out_ok);
    debug_emulator_model_inst.set_pin(1'b0);
    tick(1);
    por_active <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      tick(1);
      boot_jump_bit <= (i != 0);
      hw_boot_entry <= (i == 1);
      lock_bit_set <= (i == 2);
      tick(4);
      #1 check_bit("blocked", 1'b0, debug_active);
      rd(`A_STATE, (i == 2) ? 16'h0008 : 16'h0004, "state");
    end
    tick(1);
    {boot_jump_bit, lock_bit_set} <= 2'b10;
    tick(6);
    rd(`A_STATE, 16'h0001, "state idle");
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000, "unmapped");
    wr(`A_STATUS, 16'hFFFF);
    rd(`A_STATUS, 16'h0000, "status ro");
    for (int i = 0; i < 4; i++) begin
      wr(5'(8 + i), 16'h1000 + 16'(i * 16));
      wr(`A_BPCFG, 16'(1 << i));
      cpu_pc <= 16'h1000 + 16'(i * 16);
      tick(2);
      cpu_pc <= 16'hFFF0;
      #1 check_bit("irq masked", 1'b0, irq);
      hit(16'h0001);
    end
    wr(`A_MASK, 16'h0001);
    cpu_pc <= 16'h1030;
    tick(2);
    cpu_pc <= 16'hFFF0;
    #1 check_bit("irq", 1'b1, irq);
    hit(16'h0001);
    #1 check_bit("irq cleared", 1'b0, irq);
    wr(5'h0C, 16'h2000);
    wr(5'h0D, 16'h00FF);
    wr(`A_BPCFG, 16'h0530);
    {cpu_dvalid, cpu_daddr} <= {1'b1, 16'h21AB};
    tick(3);
    #1 check_bit("pair miss", 1'b0, cpu_halt);
    cpu_daddr <= 16'h20AB;
    tick(2);
    cpu_dvalid <= 1'b0;
    hit(16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(`A_HALTSRC, 16'(1 << i));
      ev <= 4'(1 << i);
      tick(1);
      ev <= 4'h0;
      tick(1);
      hit(16'h0004);
    end
    wr(`A_HALTSRC, 16'h0000);
    ev <= 4'hF;
    tick(1);
    ev <= 4'h0;
    tick(2);
    #1 check_bit("no halt", 1'b0, cpu_halt);
    n0 = he_n;
    tick(1);
    cpu_pc <= 16'h0100;
    cpu_break_insn <= 1'b1;
    tick(1);
    cpu_break_insn <= 1'b0;
    tick(2);
    #1 check_word("handler", 16'(n0 + 1), 16'(he_n));
    check_word("resume_pc", 16'h0102, resume_pc);
    hit(16'h0002);
    frame(OP_HALT, 16'h0000, 8'h00);
    #1 check_bit("link halt", 1'b1, cpu_halt);
    frame(OP_STEP, 16'h0000, 8'h00);
    #1 check_bit("step released", 1'b0, cpu_halt);
    tick(1);
    cpu_insn_done <= 1'b1;
    tick(1);
    cpu_insn_done <= 1'b0;
    tick(1);
    hit(16'h0000);
    n0 = we_n;
    frame(OP_WRITE, 16'h0040, 8'h5A);
    #1 check_word("mem_we count", 16'(n0 + 1), 16'(we_n));
    check_word("mem_addr", 16'h0040, we_a);
    check_word("mem_wdata", 16'h005A, {8'h00, we_d});
    n0 = re_n;
    debug_emulator_model_inst.send({OP_READ, 5'h00, 16'h0041, 8'h00});
    debug_emulator_model_inst.get_reply(rep);
    #1 check_word("reply", 16'h00C3, {8'h00, rep});
    check_word("mem_re count", 16'(n0 + 1), 16'(re_n));
    check_bit("reply oe", 1'b0, pin43_oe);
    n0 = tr_n;
    frame(OP_RESET, 16'h0000, 8'h00);
    #1 check_word("link reset", 16'(n0 + 1), 16'(tr_n));
    rd(`A_STATUS, 16'h0008, "status reset");
    print_verdict();
  end
endmodule : two_wire_debug_port_control_bench
`default_nettype wire
